// ### hdl/aso_pkg.sv
// constants and types for the serial readout block
package aso_pkg;
  localparam int unsigned WORD_W = 20;
  localparam logic [4:0] WORD_LAST = 5'h13;
  localparam logic [7:0] CFG_LEGACY = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned LANE_LSB = 2;
  localparam int unsigned RATE_BIT = 4;
  localparam int unsigned CLKSRC_LSB = 6;
  localparam logic [1:0] MODE_SRC = 2'h3;
  localparam logic [1:0] LANE_DUAL = 2'h2;
  localparam logic [1:0] LANE_QUAD = 2'h3;
  localparam logic [1:0] CLK_SCLK = 2'h0;
  localparam logic [1:0] CLK_INT = 2'h1;
  localparam logic [1:0] CLK_DIV2 = 2'h2;
  localparam logic [1:0] CLK_DIV4 = 2'h3;
  localparam logic [1:0] DIV_WRAP1 = 2'h0;
  localparam logic [1:0] DIV_WRAP2 = 2'h1;
  localparam logic [1:0] DIV_WRAP4 = 2'h3;
  localparam logic [4:0] STEP_ONE = 5'h01;
  localparam logic [4:0] STEP_TWO = 5'h02;
  localparam logic [4:0] STEP_FOUR = 5'h04;
  typedef enum logic [1:0] {ASO_IDLE, ASO_SPI, ASO_SRC} aso_state_e;
endpackage

// ### hdl/aso_strobe_gen.sv
// strobe tick generator for source-synchronous readout
`timescale 1ns/1ps
module aso_strobe_gen
  import aso_pkg::*;
(
  input wire logic mclk_i, // system clock
  input wire logic resetn_i, // sync reset, low active
  input wire logic run_i, // frame active
  input wire logic [1:0] src_i, // strobe clock source
  input wire logic sclk_rise_i, // host serial clock rising pulse
  output logic tick_o // one strobe half-period step
);
  import aso_pkg::*;

  typedef struct packed {
    logic [1:0] div;
  } aso_sg_s;

  aso_sg_s s_reg, s_next;
  logic [1:0] wrap;

  // divider wrap point by source; the internal clock is mclk itself
  always_comb begin
    s_next = s_reg;
    wrap = DIV_WRAP1;
    if (src_i == CLK_DIV2) begin
      wrap = DIV_WRAP2;
    end else if (src_i == CLK_DIV4) begin
      wrap = DIV_WRAP4;
    end
    if (!run_i || s_reg.div == wrap) begin
      s_next.div = 2'h0;
    end else begin
      s_next.div = s_reg.div + 2'h1;
    end
    if (src_i == CLK_SCLK) begin
      tick_o = run_i && sclk_rise_i;
    end else begin
      tick_o = run_i && (s_reg.div == wrap);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // aso_strobe_gen

// ### hdl/aso_readout.sv
// output-side serial readout of the 20-bit data word
`timescale 1ns/1ps
module aso_readout
  import aso_pkg::*;
#(
  parameter int unsigned DATA_W = WORD_W // output word width
) (
  input wire logic mclk_i, // 200 MHz system clock
  input wire logic resetn_i, // sync reset, low active
  input wire logic cs_n_i, // chip select, low active
  input wire logic sclk_i, // host serial clock, sampled
  input wire logic sdi_i, // serial input, chain data
  input wire logic [7:0] output_protocol_config_i, // output protocol config byte
  input wire logic [1:0] write_protocol_select_i, // clock polarity/phase
  input wire logic load_i, // new conversion word valid
  input wire logic [DATA_W-1:0] word_i, // conversion word
  output logic [3:0] sdo_o, // lanes zero to three
  output logic [3:0] sdo_oe_o, // lane enables, high drives
  output logic ready_strobe_output_o, // ready/strobe pin
  output logic busy_o // frame in progress
);
  import aso_pkg::*;

  typedef struct packed {
    aso_state_e st;
    logic sclk_d;
    logic [DATA_W-1:0] shreg;
    logic [4:0] sent;
    logic [3:0] sdo;
    logic [3:0] oe;
    logic strobe;
    logic hold;
    logic [7:0] cfg;
    logic [DATA_W-1:0] word;
  } aso_rd_s;

  aso_rd_s s_reg, s_next;
  logic sclk_rise, sclk_fall, launch, capture, tick;
  logic [4:0] step;

  // lane count to bits per launch
  function automatic logic [4:0] lane_step(input logic [1:0] code);
    if (code == LANE_QUAD) begin
      return STEP_FOUR;
    end else if (code == LANE_DUAL) begin
      return STEP_TWO;
    end
    return STEP_ONE;
  endfunction

  // lane enable mask by lane count
  function automatic logic [3:0] lane_mask(input logic [1:0] code);
    if (code == LANE_QUAD) begin
      return 4'hF;
    end else if (code == LANE_DUAL) begin
      return 4'h3;
    end
    return 4'h1;
  endfunction

  assign sclk_rise = sclk_i && !s_reg.sclk_d;
  assign sclk_fall = !sclk_i && s_reg.sclk_d;

  aso_strobe_gen u_strobe (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .run_i(s_reg.st == ASO_SRC),
    .src_i(s_reg.cfg[CLKSRC_LSB +: 2]),
    .sclk_rise_i(sclk_rise),
    .tick_o(tick)
  );

  // phase 0 launches on trailing edge (MSB preset at cs fall), phase 1 on leading
  always_comb begin
    launch = 1'b0;
    capture = 1'b0;
    case (write_protocol_select_i)
      2'h0: begin
        launch = sclk_fall;
        capture = sclk_rise;
      end
      2'h1: begin
        launch = sclk_rise;
        capture = sclk_fall;
      end
      2'h2: begin
        launch = sclk_rise;
        capture = sclk_fall;
      end
      default: begin
        launch = sclk_fall;
        capture = sclk_rise;
      end
    endcase
  end

  // bits moved per launch
  assign step = lane_step(s_reg.cfg[LANE_LSB +: 2]);

  // state update: one frame per chip-select low
  always_comb begin
    s_next = s_reg;
    s_next.sclk_d = sclk_i;
    case (s_reg.st)
      ASO_IDLE: begin
        s_next.oe = 4'h0;
        s_next.strobe = 1'b0;
        s_next.hold = 1'b0;
        // word kept apart from the shifter so a cut frame can be read again
        if (load_i) begin
          s_next.word = word_i;
        end
        if (!cs_n_i) begin
          // config latched per frame; bit position restarts here
          s_next.cfg = output_protocol_config_i;
          s_next.shreg = s_next.word;
          s_next.sent = 5'h00;
          if (output_protocol_config_i[MODE_LSB +: 2] == MODE_SRC) begin
            s_next.st = ASO_SRC;
            s_next.oe = lane_mask(output_protocol_config_i[LANE_LSB +: 2]);
            s_next.sdo = 4'h0;
          end else begin
            s_next.st = ASO_SPI;
            s_next.oe = lane_mask(output_protocol_config_i[LANE_LSB +: 2]);
            s_next.hold = write_protocol_select_i[0];
            s_next.sdo = {s_next.shreg[DATA_W-4], s_next.shreg[DATA_W-3],
                          s_next.shreg[DATA_W-2], s_next.shreg[DATA_W-1]};
            if (!write_protocol_select_i[0]) begin
              s_next.shreg = s_next.shreg << lane_step(output_protocol_config_i[LANE_LSB +: 2]);
              s_next.sent = lane_step(output_protocol_config_i[LANE_LSB +: 2]);
            end
          end
        end
      end
      ASO_SPI: begin
        s_next.strobe = 1'b0;
        if (launch) begin
          s_next.hold = 1'b0;
          s_next.sdo = {s_reg.shreg[DATA_W-4], s_reg.shreg[DATA_W-3],
                        s_reg.shreg[DATA_W-2], s_reg.shreg[DATA_W-1]};
          s_next.shreg = s_reg.shreg << step;
          if (s_reg.sent <= WORD_LAST) begin
            s_next.sent = s_reg.sent + step;
          end
        end
        // chain mode: capture edge feeds sdi into the vacated LSB
        if (capture && !s_reg.hold && s_reg.cfg == CFG_LEGACY) begin
          s_next.shreg[0] = sdi_i;
          if (launch) begin
            s_next.shreg = (s_reg.shreg << step) | {{(DATA_W-1){1'b0}}, sdi_i};
          end
        end
        if (cs_n_i) begin
          s_next.st = ASO_IDLE;
          s_next.oe = 4'h0;
        end
      end
      ASO_SRC: begin
        if (tick) begin
          // single rate: rise launches, fall idles; double rate: both launch
          s_next.strobe = !s_reg.strobe;
          if (!s_reg.strobe || s_reg.cfg[RATE_BIT]) begin
            s_next.sdo = {s_reg.shreg[DATA_W-4], s_reg.shreg[DATA_W-3],
                          s_reg.shreg[DATA_W-2], s_reg.shreg[DATA_W-1]};
            s_next.shreg = s_reg.shreg << step;
            if (s_reg.sent <= WORD_LAST) begin
              s_next.sent = s_reg.sent + step;
            end
          end
        end
        if (cs_n_i) begin
          s_next.st = ASO_IDLE;
          s_next.oe = 4'h0;
          s_next.strobe = 1'b0;
        end
      end
      default: begin
        s_next.st = ASO_IDLE;
      end
    endcase
  end

  // reset leaves mode 00, single lane
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s_reg <= '0;
      s_reg.cfg <= CFG_RESET;
      s_reg.st <= ASO_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sdo_o = s_reg.sdo & s_reg.oe;
  assign sdo_oe_o = s_reg.oe;
  assign ready_strobe_output_o = s_reg.strobe;
  assign busy_o = (s_reg.st != ASO_IDLE);

  a_spi_strobe_low: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (s_reg.st == ASO_SPI) |-> !ready_strobe_output_o) else $error("strobe high in spi frame");
  a_lanes_released: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (cs_n_i && $past(cs_n_i)) |-> ##1 (sdo_oe_o == 4'h0)) else $error("lanes driven while deselected");
  a_reset_default: assert property (@(posedge mclk_i)
    !resetn_i |=> (s_reg.cfg == CFG_RESET && sdo_oe_o == 4'h0)) else $error("reset config wrong");
  a_src_strobe_runs: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (s_reg.st == ASO_SRC && tick && !cs_n_i) |=> (ready_strobe_output_o != $past(ready_strobe_output_o)))
    else $error("strobe did not toggle");
  a_sdr_no_fall: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (s_reg.st == ASO_SRC && !s_reg.cfg[RATE_BIT] && tick && s_reg.strobe && !cs_n_i) |=> $stable(s_reg.sent))
    else $error("sdr launched on fall");
  a_ddr_both: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (s_reg.st == ASO_SRC && s_reg.cfg[RATE_BIT] && tick && s_reg.sent <= WORD_LAST && !cs_n_i)
    |=> (s_reg.sent == $past(s_reg.sent) + $past(step))) else $error("ddr missed edge");
  a_quad_oe: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (s_reg.st != ASO_IDLE && s_reg.cfg[LANE_LSB +: 2] == LANE_QUAD) |-> sdo_oe_o == 4'hF)
    else $error("quad lanes not enabled");
  a_dual_oe: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (s_reg.st != ASO_IDLE && s_reg.cfg[LANE_LSB +: 2] == LANE_DUAL) |-> sdo_oe_o == 4'h3)
    else $error("dual lanes not enabled");
  a_zero_tail: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (s_reg.st != ASO_IDLE && s_reg.cfg != CFG_LEGACY && s_reg.sent > WORD_LAST && s_reg.shreg == '0
     && (launch || tick)) |=> (sdo_o == 4'h0 || cs_n_i)) else $error("nonzero tail");
endmodule // aso_readout

// ### tb/aso_host_model.sv
// host controller model: frames, serial clock and lane capture
`timescale 1ns/1ps
module aso_host_model
  import aso_pkg::*;
#(
  parameter int H = 4 // sclk half period in mclk cycles
) (
  input wire logic mclk_i, // system clock
  output logic cs_n_o, // chip select, low active
  output logic sclk_o, // host serial clock
  input wire logic [3:0] sdo_i, // readout lanes
  input wire logic strobe_i // ready/strobe pin
);
  logic spi_q; // spi frame running
  logic strobe_bad; // sticky: strobe not low in an spi frame
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    spi_q = 1'b0;
    strobe_bad = 1'b0;
  end
  // one settled sample point per mclk
  task automatic step();
    @(posedge mclk_i);
    #1;
    if (spi_q && strobe_i !== 1'b0) strobe_bad = 1'b1;
  endtask
  // lane zero carries the most significant bit of a launch
  task automatic grab(input int n, inout logic [31:0] cap);
    for (int j = 0; j < n; j++) cap = {cap[30:0], sdo_i[j]};
  endtask
  // read frames only, no register writes
  task automatic run_frame(input logic [7:0] cfg, input logic [1:0] pm, input int nb, output logic [31:0] cap);
    int n;
    int got;
    int t;
    logic prev;
    n = (cfg[3:2] == LANE_QUAD) ? 4 : (cfg[3:2] == LANE_DUAL) ? 2 : 1;
    cap = '0;
    got = 0;
    t = 0;
    prev = 1'b0;
    sclk_o = pm[1];
    step();
    cs_n_o = 1'b0;
    spi_q = (cfg[1:0] != MODE_SRC);
    if (spi_q) begin
      repeat (H) step();
      // capture on the edge opposite the launch edge
      for (int k = 0; k < nb / n; k++) begin
        if (!pm[0]) grab(n, cap);
        sclk_o = ~sclk_o;
        repeat (H) step();
        if (pm[0]) grab(n, cap);
        sclk_o = ~sclk_o;
        repeat (H) step();
      end
    end else begin
      // follow the strobe; sclk runs only when it is the source
      while (got < nb && t < 4000) begin
        if (cfg[7:6] == CLK_SCLK && t % H == 0) sclk_o = ~sclk_o;
        step();
        t++;
        if (strobe_i !== prev && (strobe_i || cfg[RATE_BIT])) begin
          grab(n, cap);
          got += n;
        end
        prev = strobe_i;
      end
    end
    spi_q = 1'b0;
    cs_n_o = 1'b1;
    sclk_o = pm[1];
  endtask
endmodule // aso_host_model

// ### tb/aso_readout_tb_top.sv
// self-checking bench for the serial readout block
`timescale 1ns/1ps
module aso_readout_tb_top;
  import aso_pkg::*;
  typedef struct {logic [7:0] cfg; logic [1:0] pm; int nb; logic sdi; logic [19:0] w; logic [31:0] exp;} aso_row_s;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic sdi = 1'b0;
  logic [7:0] cfg = 8'h00;
  logic [1:0] pm = 2'h0;
  logic load = 1'b0;
  logic [WORD_W-1:0] word = 20'h00000;
  logic cs_n;
  logic sclk;
  logic [3:0] sdo;
  logic [3:0] oe;
  logic strobe;
  logic busy;
  logic [31:0] cap;
  aso_row_s rows[$];
  aso_row_s r;
  int mismatches = 0;
  int checked = 0;
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  aso_readout dut_u (.mclk_i(mclk), .resetn_i(resetn), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
    .output_protocol_config_i(cfg), .write_protocol_select_i(pm), .load_i(load), .word_i(word),
    .sdo_o(sdo), .sdo_oe_o(oe), .ready_strobe_output_o(strobe), .busy_o(busy));
  aso_host_model host_u (.mclk_i(mclk), .cs_n_o(cs_n), .sclk_o(sclk), .sdo_i(sdo), .strobe_i(strobe));
  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // word msb first, then chain bits for config 00h or zeros otherwise
  task automatic add(input logic [7:0] c, input logic [1:0] p, input int nb, input logic s);
    aso_row_s x;
    x = '{c, p, nb, s, 20'hB4E27 + 20'h01357 * rows.size(), 32'h0};
    x.exp = {12'h000, x.w};
    if (nb < 20) x.exp = x.exp >> (20 - nb);
    for (int k = 20; k < nb; k++) x.exp = {x.exp[30:0], s & (c == CFG_LEGACY)};
    rows.push_back(x);
  endtask
  // load a word while idle, run one frame, let the lanes release
  task automatic do_frame(input aso_row_s x);
    cfg = x.cfg;
    pm = x.pm;
    sdi = x.sdi;
    word = x.w;
    load = 1'b1;
    @(posedge mclk);
    #1;
    load = 1'b0;
    host_u.run_frame(x.cfg, x.pm, x.nb, cap);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    #1;
    resetn = 1'b1;
    check_val("oe_reset", 32'h0, 32'(oe));
    check_val("strobe_reset", 32'h0, 32'(strobe));
    for (int p = 0; p < 4; p++)
      for (int l = 0; l < 4; l++) add({4'h0, 2'(l), 2'h0}, 2'(p), 20, 1'b0);
    for (int c = 0; c < 4; c++)
      for (int l = 0; l < 4; l++)
        for (int d = 0; d < 2; d++) add({2'(c), 1'b0, 1'(d), 2'(l), MODE_SRC}, 2'h0, 20, 1'b0);
    add(8'h00, 2'h0, 24, 1'b1);
    add(8'h0C, 2'h1, 24, 1'b1);
    add(8'h08, 2'h3, 24, 1'b1);
    foreach (rows[i]) begin
      do_frame(rows[i]);
      if (rows[i].cfg[1:0] == MODE_SRC) check_val("src_word", rows[i].exp, cap);
      else check_val("spi_word", rows[i].exp, cap);
      check_val("oe_idle", 32'h0, 32'(oe));
      check_val("busy_idle", 32'h0, 32'(busy));
      check_val("spi_strobe", 32'h0, 32'(host_u.strobe_bad));
    end
    // aborted quad frame with a refused load inside, then a full frame
    r = rows[3];
    r.nb = 8;
    fork
      do_frame(r);
      begin
        repeat (6) @(posedge mclk);
        #1;
        check_val("busy_frame", 32'h1, 32'(busy));
        word = ~r.w;
        load = 1'b1;
        @(posedge mclk);
        #1;
        load = 1'b0;
      end
    join
    check_val("abort_top", {12'h000, r.w} >> 12, cap);
    host_u.run_frame(r.cfg, r.pm, 20, cap);
    check_val("restart", {12'h000, r.w}, cap);
    stop_test();
  end
  // about 50 frames of under 400 cycles each; far beyond that is a hang
  initial begin
    #300000;
    mismatches++;
    stop_test();
  end
endmodule // aso_readout_tb_top
